// ---- hdl/dpe_event_dma.sv ----
// event capture, priority encoding and dispatch for the two-engine data mover
`timescale 1ns/10ps
// What this block does
// - each event state bit tracks its event line level.
// - only a level change counts as an event.
// - per-event polarity picks rising or falling edge for capture.
// - a captured event starts a transfer or raises a cpu interrupt.
// - high group served by high engine only, low group by low engine.
// - parameter ram holds event table and transfer table.
// - transfer table holds at most eight entries, picked by pointer.
// - interrupt-type entry raises the interrupt it names.
// - mode from event entry; addresses, counts, indexes from transfer entry.
// - high-group entries come from high ram, low-group from low ram.
// - up to 31 events captured, several may pend together.
// - encoder orders simultaneous pending events by priority.
// - one event per group processed at a time, both groups concurrently.
// - concurrent transfers only when they touch different slaves.
// - crossbar grants high engine, then low engine, then others.
// - software toggles a trigger bit to make an edge on its event.
// - trigger bits 0,16,1,17,2,18,3,19,20,21 feed events 0,1,10,11,17,18,23,24,30,31.
// - timer, audio, host, serial and two-wire requests map to fixed events.
// - events 26-28 OR mute and audio interrupts; 29 timer overflow; 25 reserved.
module dpe_event_dma (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic timer_request_0,
  input wire logic timer_request_1,
  input wire logic timer_request_2,
  input wire logic timer_request_3,
  input wire logic audio0_tx_request,
  input wire logic audio0_rx_request,
  input wire logic audio1_tx_request,
  input wire logic audio1_rx_request,
  input wire logic audio2_tx_request,
  input wire logic audio2_rx_request,
  input wire logic host_port_interrupt,
  input wire logic serial0_rx_request,
  input wire logic serial1_rx_request,
  input wire logic twowire0_tx_event,
  input wire logic twowire0_rx_event,
  input wire logic twowire1_tx_event,
  input wire logic twowire1_rx_event,
  input wire logic [2:0] external_mute_in,
  input wire logic [2:0] audio_tx_int,
  input wire logic [2:0] audio_rx_int,
  input wire logic timer_overflow_error,
  input wire logic [2:0] other_req,
  input wire logic [8:0] other_slv,
  output logic [2:0] other_gnt,
  output logic [dpe_pkg::NUM_IRQ-1:0] cpu_irq,
  output logic high_engine_move,
  output logic [31:0] high_engine_src,
  output logic [31:0] high_engine_dst,
  output logic low_engine_move,
  output logic [31:0] low_engine_src,
  output logic [31:0] low_engine_dst
);
  import dpe_pkg::*;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [NUM_EVT-1:0] pin_raw;
  logic [NUM_EVT-1:0] pin_meta_ff;
  logic [NUM_EVT-1:0] pin_sync_ff;
  logic [NUM_EVT-1:0] trig_map;
  logic [NUM_EVT-1:0] event_state_reg;
  logic [NUM_EVT-1:0] state_prev_ff;
  logic [NUM_EVT-1:0] edge_hit;
  logic [NUM_EVT-1:0] event_capture_flags;
  logic [NUM_EVT-1:0] polarity_ff;
  logic [NUM_EVT-1:0] enable_ff;
  logic [NUM_EVT-1:0] high_grp_ff;
  logic [31:0] software_trigger_reg;
  logic [31:0] evt_mem [2][NUM_EVT];
  logic [31:0] xfr_mem [2][NUM_XFER*XFER_WORDS];
  logic [NUM_EVT-1:0] disp_clr;
  logic [NUM_EVT-1:0] sw_clr;
  logic [NUM_IRQ-1:0] nxt_irq;
  logic [1:0] eng_busy;
  logic [1:0] eng_done;
  logic [1:0] eng_start;
  logic [4:0] eng_cfg [2];
  logic [1:0] disp_valid;
  logic [4:0] disp_idx [2];
  dpe_evt_entry_t disp_entry [2];
  logic [31:0] src_w [2];
  logic [31:0] dst_w [2];
  logic [31:0] cnt_w [2];
  logic [31:0] idx_w [2];
  logic [31:0] eng_src [2];
  logic [31:0] eng_dst [2];
  logic [1:0] eng_move;
  logic dph_wr_ff;
  logic dph_rd_ff;
  logic [11:0] dph_addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_mux;
  logic addr_phase;

  dpe_xbar_if eng_bus [2] ();

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // peripheral requests onto fixed event numbers
  // error events merge mute input with the port's interrupts; 25 stays low
  always_comb begin
    pin_raw = '0;
    pin_raw[2] = timer_request_0;
    pin_raw[3] = timer_request_1;
    pin_raw[4] = audio0_tx_request;
    pin_raw[5] = audio0_rx_request;
    pin_raw[6] = audio1_tx_request;
    pin_raw[7] = audio1_rx_request;
    pin_raw[8] = audio2_tx_request;
    pin_raw[9] = audio2_rx_request;
    pin_raw[12] = host_port_interrupt;
    pin_raw[13] = serial0_rx_request;
    pin_raw[14] = serial1_rx_request;
    pin_raw[15] = timer_request_2;
    pin_raw[16] = timer_request_3;
    pin_raw[19] = twowire0_tx_event;
    pin_raw[20] = twowire0_rx_event;
    pin_raw[21] = twowire1_tx_event;
    pin_raw[22] = twowire1_rx_event;
    for (int a = 0; a < 3; a++) begin
      pin_raw[26 + a] = external_mute_in[a] | audio_tx_int[a] | audio_rx_int[a];
    end
    pin_raw[29] = timer_overflow_error;
  end

  // two-stage synchroniser ahead of any edge logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // trigger bits are same-clock, so they join the state without a synchroniser
  // trigger bit to event number mapping
  always_comb begin
    trig_map = '0;
    for (int t = 0; t < NUM_TRIG; t++) begin
      trig_map[TRIG_EVT[t]] = software_trigger_reg[TRIG_BIT[t]];
    end
  end

  // state follows the (synchronised) line level
  assign event_state_reg = pin_sync_ff | trig_map;

  // compare against last cycle, so a steady level never captures
  // polarity 1 captures rising edges, 0 captures falling edges
  assign edge_hit = polarity_ff & event_state_reg & ~state_prev_ff
                  | ~polarity_ff & ~event_state_reg & state_prev_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_prev_ff <= '0;
    end else begin
      state_prev_ff <= event_state_reg;
    end
  end

  // sticky flags; a new edge wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_capture_flags <= '0;
    end else begin
      event_capture_flags <= (event_capture_flags & ~(sw_clr | disp_clr) | edge_hit)
                             & ~(NUM_EVT'(1) << RESERVED_EVT);
    end
  end

  // per group: pick, fetch entries from that group's ram, and hand to its engine
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_grp
      logic [NUM_EVT-1:0] pend;
      // group 0 holds events marked high, group 1 the rest
      // entries are trusted once software has enabled the event
      assign pend = event_capture_flags & enable_ff & (g == 0 ? high_grp_ff : ~high_grp_ff);

      // lowest event number has the highest priority
      always_comb begin
        disp_idx[g] = 5'd0;
        for (int e = NUM_EVT - 1; e >= 0; e--) begin
          if (pend[e]) begin
            disp_idx[g] = 5'(e);
          end
        end
      end

      // dispatch only while this group's engine is idle
      assign disp_valid[g] = |pend && !eng_busy[g];

      // event entry first, then the transfer entry it points at
      // each group reads only its own parameter ram
      assign disp_entry[g] = dpe_evt_entry_t'(evt_mem[g][disp_idx[g]]);
      // three pointer bits reach exactly eight transfer entries
      assign src_w[g] = xfr_mem[g][{disp_entry[g].ptr, 2'(XW_SRC)}];
      assign dst_w[g] = xfr_mem[g][{disp_entry[g].ptr, 2'(XW_DST)}];
      assign cnt_w[g] = xfr_mem[g][{disp_entry[g].ptr, 2'(XW_CNT)}];
      assign idx_w[g] = xfr_mem[g][{disp_entry[g].ptr, 2'(XW_IDX)}];

      // transfer kind starts the engine; interrupt kind does not
      assign eng_start[g] = disp_valid[g] && disp_entry[g].kind == KIND_XFER;

      dpe_engine u_engine (
        .clk(clk),
        .rst_n(rst_n),
        .start(eng_start[g]),
        .entry(disp_entry[g]),
        .src_word(src_w[g]),
        .dst_word(dst_w[g]),
        .cnt_word(cnt_w[g]),
        .idx_word(idx_w[g]),
        .bus(eng_bus[g]),
        .busy(eng_busy[g]),
        .done(eng_done[g]),
        .move_ff(eng_move[g]),
        .src_ff(eng_src[g]),
        .dst_ff(eng_dst[g]),
        .cfg_ff(eng_cfg[g])
      );
    end
  endgenerate

  always_comb begin
    disp_clr = '0;
    nxt_irq = '0;
    for (int k = 0; k < 2; k++) begin
      if (disp_valid[k]) begin
        disp_clr[disp_idx[k]] = 1'b1;
        // raise the interrupt line named in the entry
        if (disp_entry[k].kind == KIND_IRQ) begin
          nxt_irq[disp_entry[k].irq] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_irq <= '0;
    end else begin
      cpu_irq <= nxt_irq;
    end
  end

  dpe_xbar_arb u_arb (
    .clk(clk),
    .rst_n(rst_n),
    .hi(eng_bus[0]),
    .lo(eng_bus[1]),
    .other_req(other_req),
    .other_slv(other_slv),
    .other_gnt(other_gnt)
  );

  assign high_engine_move = eng_move[0];
  assign high_engine_src = eng_src[0];
  assign high_engine_dst = eng_dst[0];
  assign low_engine_move = eng_move[1];
  assign low_engine_src = eng_src[1];
  assign low_engine_dst = eng_dst[1];

  // bus slave: writes take effect with no wait, reads insert one wait to register data
  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout = !dph_rd_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dph_wr_ff <= 1'b0;
      dph_rd_ff <= 1'b0;
      dph_addr_ff <= 12'h000;
    end else begin
      dph_rd_ff <= addr_phase && !hwrite;
      if (hready) begin
        dph_wr_ff <= addr_phase && hwrite;
        dph_addr_ff <= {haddr[11:2], 2'b00};
      end
    end
  end

  always_comb begin
    case (dph_addr_ff)
      OFS_POLARITY: rd_mux = polarity_ff;
      OFS_EN_SET, OFS_EN_CLR: rd_mux = enable_ff;
      OFS_HP_SET, OFS_HP_CLR: rd_mux = high_grp_ff;
      OFS_FLAGS: rd_mux = event_capture_flags;
      OFS_TRIGGER: rd_mux = software_trigger_reg;
      OFS_STATUS: rd_mux = {18'h0_0000, eng_cfg[1], eng_busy[1], 2'b00, eng_cfg[0], eng_busy[0]};
      OFS_STATE: rd_mux = event_state_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (dph_addr_ff[11:RAM_GRP_BIT + 1] == 2'b00 && dph_addr_ff[8] != dph_addr_ff[RAM_GRP_BIT]) begin
      rd_mux = dph_addr_ff[RAM_TBL_BIT] ? xfr_mem[dph_addr_ff[RAM_GRP_BIT]][dph_addr_ff[6:2]]
                                        : evt_mem[dph_addr_ff[RAM_GRP_BIT]][dph_addr_ff[6:2]];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (dph_rd_ff) begin
      hrdata_ff <= rd_mux;
    end
  end

  assign sw_clr = (dph_wr_ff && dph_addr_ff == OFS_FLAGS) ? hwdata : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      polarity_ff <= RST_POLARITY;
      enable_ff <= RST_ENABLE;
      high_grp_ff <= RST_HIGH_GRP;
      software_trigger_reg <= RST_TRIGGER;
    end else if (dph_wr_ff) begin
      case (dph_addr_ff)
        OFS_POLARITY: polarity_ff <= hwdata;
        OFS_EN_SET: enable_ff <= enable_ff | hwdata;
        OFS_EN_CLR: enable_ff <= enable_ff & ~hwdata;
        OFS_HP_SET: high_grp_ff <= high_grp_ff | hwdata;
        OFS_HP_CLR: high_grp_ff <= high_grp_ff & ~hwdata;
        OFS_TRIGGER: software_trigger_reg <= hwdata;
        default: ;
      endcase
    end
  end

  // parameter rams are plain storage, no reset
  always_ff @(posedge clk) begin
    if (dph_wr_ff && dph_addr_ff[11:RAM_GRP_BIT + 1] == 2'b00
        && dph_addr_ff[8] != dph_addr_ff[RAM_GRP_BIT]) begin
      if (dph_addr_ff[RAM_TBL_BIT]) begin
        xfr_mem[dph_addr_ff[RAM_GRP_BIT]][dph_addr_ff[6:2]] <= hwdata;
      end else begin
        evt_mem[dph_addr_ff[RAM_GRP_BIT]][dph_addr_ff[6:2]] <= hwdata;
      end
    end
  end

  sequence s_trig_write;
    dph_wr_ff && dph_addr_ff == OFS_TRIGGER;
  endsequence

  a_trig_state: assert property (@(posedge clk) disable iff (!rst_n)
    s_trig_write |=> event_state_reg[0] == ($past(hwdata[0]) | pin_sync_ff[0]))
    else $error("trigger bit 0 did not reach event 0");

  a_rise_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (polarity_ff[0] && event_state_reg[0] && !state_prev_ff[0]) |=> event_capture_flags[0])
    else $error("rising edge on event 0 not captured");

  a_fall_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (!polarity_ff[2] && !event_state_reg[2] && state_prev_ff[2]) |=> event_capture_flags[2])
    else $error("falling edge on event 2 not captured");

  a_level_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!event_capture_flags[4] && event_state_reg[4] == state_prev_ff[4]) |=> !event_capture_flags[4])
    else $error("steady level set a flag");

  a_reserved_low: assert property (@(posedge clk) disable iff (!rst_n)
    !event_capture_flags[RESERVED_EVT])
    else $error("reserved event flagged");

  a_high_group: assert property (@(posedge clk) disable iff (!rst_n)
    disp_valid[0] |-> high_grp_ff[disp_idx[0]] && enable_ff[disp_idx[0]])
    else $error("high engine took a low-group event");

  a_one_per_grp: assert property (@(posedge clk) disable iff (!rst_n)
    eng_start[1] |=> eng_busy[1] && !eng_start[1])
    else $error("second event started on a busy engine");

  a_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
    (disp_valid[1] && disp_entry[1].kind == KIND_IRQ) |=> cpu_irq[$past(disp_entry[1].irq)])
    else $error("named interrupt not raised");

  a_reset_idle: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> eng_busy == 2'b00 && event_capture_flags == '0)
    else $error("not idle after reset");
endmodule

// ---- hdl/dpe_pkg.sv ----
// constants, field layouts and types shared by the event dispatch block
package dpe_pkg;

  localparam int NUM_EVT = 32;
  localparam int NUM_XFER = 8;
  localparam int XFER_WORDS = 4;
  localparam int NUM_PORTS = 5;
  localparam int NUM_IRQ = 8;
  localparam int RESERVED_EVT = 25;
  localparam int NUM_TRIG = 10;

  // register byte offsets
  localparam logic [11:0] OFS_POLARITY = 12'h008;
  localparam logic [11:0] OFS_EN_SET = 12'h00C;
  localparam logic [11:0] OFS_EN_CLR = 12'h010;
  localparam logic [11:0] OFS_HP_SET = 12'h014;
  localparam logic [11:0] OFS_HP_CLR = 12'h018;
  localparam logic [11:0] OFS_FLAGS = 12'h01C;
  localparam logic [11:0] OFS_TRIGGER = 12'h020;
  localparam logic [11:0] OFS_STATUS = 12'h024;
  localparam logic [11:0] OFS_STATE = 12'h034;
  // parameter ram windows: [9] picks the group ([8] is its complement), [7] the table
  localparam logic [11:0] OFS_HI_EVT = 12'h100;
  localparam logic [11:0] OFS_LO_EVT = 12'h200;
  localparam int RAM_GRP_BIT = 9;
  localparam int RAM_TBL_BIT = 7;

  // reset values
  localparam logic [31:0] RST_POLARITY = 32'h0000_0000;
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_HIGH_GRP = 32'h0000_0000;
  localparam logic [31:0] RST_TRIGGER = 32'h0000_0000;

  // transfer entry word order
  localparam int XW_SRC = 0;
  localparam int XW_DST = 1;
  localparam int XW_CNT = 2;
  localparam int XW_IDX = 3;

  // software trigger bit -> event number
  localparam int TRIG_BIT [NUM_TRIG] = '{0, 16, 1, 17, 2, 18, 3, 19, 20, 21};
  localparam int TRIG_EVT [NUM_TRIG] = '{0, 1, 10, 11, 17, 18, 23, 24, 30, 31};

  typedef enum logic [1:0] {
    KIND_OFF = 2'b00,
    KIND_XFER = 2'b01,
    KIND_IRQ = 2'b10
  } dpe_kind_t;

  typedef struct packed {
    logic [16:0] spare;
    logic [2:0] irq;
    logic pad1;
    logic [2:0] ptr;
    logic pad0;
    logic [1:0] esize;
    logic reload;
    logic [1:0] sync;
    logic [1:0] kind;
  } dpe_evt_entry_t;

endpackage

// ---- hdl/dpe_xbar_if.sv ----
// request and grant between one transfer engine and the crossbar arbiter
`timescale 1ns/10ps
interface dpe_xbar_if;
  logic req;
  logic [2:0] slv;
  logic gnt;
  modport master (output req, output slv, input gnt);
  modport arb (input req, input slv, output gnt);
endinterface

// ---- hdl/dpe_xbar_arb.sv ----
// fixed priority crossbar arbiter: high engine, low engine, then other masters
`timescale 1ns/10ps
module dpe_xbar_arb (
  input wire logic clk,
  input wire logic rst_n,
  dpe_xbar_if.arb hi,
  dpe_xbar_if.arb lo,
  input wire logic [2:0] other_req,
  input wire logic [8:0] other_slv,
  output logic [2:0] other_gnt
);
  import dpe_pkg::*;

  logic [NUM_PORTS-1:0] req;
  logic [2:0] slv [NUM_PORTS];
  logic [NUM_PORTS-1:0] gnt;

  assign req = {other_req, lo.req, hi.req};
  assign slv[0] = hi.slv;
  assign slv[1] = lo.slv;
  assign slv[2] = other_slv[2:0];
  assign slv[3] = other_slv[5:3];
  assign slv[4] = other_slv[8:6];

  // one master per slave at a time
  genvar m;
  generate
    for (m = 0; m < NUM_PORTS; m++) begin : g_master
      always_comb begin
        gnt[m] = req[m];
        for (int k = 0; k < m; k++) begin
          if (req[k] && slv[k] == slv[m]) begin
            gnt[m] = 1'b0;
          end
        end
      end
    end
  endgenerate

  assign hi.gnt = gnt[0];
  assign lo.gnt = gnt[1];
  assign other_gnt = gnt[4:2];

  a_hi_first: assert property (@(posedge clk) disable iff (!rst_n)
    hi.req |-> hi.gnt && !(lo.req && lo.slv == hi.slv && lo.gnt))
    else $error("high engine not served first");

  a_no_share: assert property (@(posedge clk) disable iff (!rst_n)
    (hi.gnt && lo.gnt) |-> hi.slv != lo.slv)
    else $error("two engines granted the same slave");
endmodule

// ---- hdl/dpe_engine.sv ----
// one transfer engine: alternates source read and destination write per element
`timescale 1ns/10ps
module dpe_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire dpe_pkg::dpe_evt_entry_t entry,
  input wire logic [31:0] src_word,
  input wire logic [31:0] dst_word,
  input wire logic [31:0] cnt_word,
  input wire logic [31:0] idx_word,
  dpe_xbar_if.master bus,
  output logic busy,
  output logic done,
  output logic move_ff,
  output logic [31:0] src_ff,
  output logic [31:0] dst_ff,
  output logic [4:0] cfg_ff
);
  import dpe_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11,
    ST_DONE = 2'b10
  } dpe_eng_st_t;

  dpe_eng_st_t state_ff;
  logic [15:0] cnt_ff;
  logic [15:0] sidx_ff;
  logic [15:0] didx_ff;

  // slaves are decoded from the top address bits; out-of-range folds onto the last port
  function automatic logic [2:0] slave_of(input logic [31:0] a);
    slave_of = (a[30:28] < 3'(NUM_PORTS)) ? a[30:28] : 3'(NUM_PORTS - 1);
  endfunction

  assign busy = state_ff != ST_IDLE;
  assign done = state_ff == ST_DONE;
  assign bus.req = state_ff == ST_READ || state_ff == ST_WRITE;
  assign bus.slv = (state_ff == ST_READ) ? slave_of(src_ff) : slave_of(dst_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: if (start) state_ff <= ST_READ;
        ST_READ: if (bus.gnt) state_ff <= ST_WRITE;
        ST_WRITE: if (bus.gnt) state_ff <= (cnt_ff <= 16'h0001) ? ST_DONE : ST_READ;
        ST_DONE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // addresses, count and indexes from the transfer entry, mode from the event entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_ff <= 32'h0000_0000;
      dst_ff <= 32'h0000_0000;
      cnt_ff <= 16'h0000;
      sidx_ff <= 16'h0000;
      didx_ff <= 16'h0000;
      cfg_ff <= 5'h00;
    end else if (state_ff == ST_IDLE && start) begin
      src_ff <= src_word;
      dst_ff <= dst_word;
      cnt_ff <= cnt_word[15:0];
      sidx_ff <= idx_word[15:0];
      didx_ff <= idx_word[31:16];
      cfg_ff <= {entry.esize, entry.reload, entry.sync};
    end else if (state_ff == ST_WRITE && bus.gnt) begin
      src_ff <= src_ff + {{16{sidx_ff[15]}}, sidx_ff};
      dst_ff <= dst_ff + {{16{didx_ff[15]}}, didx_ff};
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      move_ff <= 1'b0;
    end else begin
      move_ff <= state_ff == ST_WRITE && bus.gnt;
    end
  end

  sequence s_elem;
    state_ff == ST_READ && bus.gnt ##1 state_ff == ST_WRITE;
  endsequence

  a_elem_walk: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ST_IDLE && start) |=> s_elem or (state_ff == ST_READ && !bus.gnt))
    else $error("engine did not begin with a source read");
endmodule

// ---- dv/dpe_periph_model.sv ----
// far-side peripheral model: holds the request, interrupt and error line levels
`timescale 1ns/10ps
module dpe_periph_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [4:0] sel,
  output logic [26:0] lines
);
  initial lines = '0;
  // a line only changes level on command
  always @(posedge clk) if (fire) lines[sel] <= ~lines[sel];
endmodule

// ---- dv/dpe_event_dma_test.sv ----
// self-checking bench for the event dispatch block
`timescale 1ns/10ps
module dpe_event_dma_test;
  import dpe_pkg::*;
  logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, fire = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] sel = '0;
  logic [26:0] ln;
  logic [7:0] irq, cpu_irq;
  logic hreadyout, hresp, hm, lm, hmv, lmv;
  logic [31:0] hs, hd, ls, ld;
  logic [2:0] oreq = '0, og;
  logic [8:0] oslv = '0;
  logic [11:0] ofs [4] = '{OFS_POLARITY, OFS_EN_SET, OFS_FLAGS, OFS_TRIGGER};
  int num_errors = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;
  dpe_periph_model far (.clk(clk), .fire(fire), .sel(sel), .lines(ln));
  dpe_event_dma dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_request_0(ln[0]),
    .timer_request_1(ln[1]), .timer_request_2(ln[2]), .timer_request_3(ln[3]),
    .audio0_tx_request(ln[4]), .audio0_rx_request(ln[5]), .audio1_tx_request(ln[6]),
    .audio1_rx_request(ln[7]), .audio2_tx_request(ln[8]), .audio2_rx_request(ln[9]),
    .host_port_interrupt(ln[10]), .serial0_rx_request(ln[11]), .serial1_rx_request(ln[12]),
    .twowire0_tx_event(ln[13]), .twowire0_rx_event(ln[14]), .twowire1_tx_event(ln[15]),
    .twowire1_rx_event(ln[16]), .timer_overflow_error(ln[17]), .external_mute_in(ln[20:18]),
    .audio_tx_int(ln[23:21]), .audio_rx_int(ln[26:24]), .other_req(oreq), .other_slv(oslv),
    .other_gnt(og), .cpu_irq(cpu_irq), .high_engine_move(hm), .high_engine_src(hs),
    .high_engine_dst(hd), .low_engine_move(lm), .low_engine_src(ls), .low_engine_dst(ld));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  // one single word transfer; request held until hready is seen high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(q, e);
  endtask

  task automatic tog(input int b);
    sel <= b[4:0];
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  // gathers every interrupt and move pulse seen in a window
  task automatic watch(input int n);
    irq = '0;
    hmv = 1'b0;
    lmv = 1'b0;
    repeat (n) begin
      @(posedge clk);
      irq |= cpu_irq;
      hmv |= hm;
      lmv |= lm;
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
    rd(12'hFF0, 32'h0000_0000);
    check(32'(hresp), 32'h0000_0000);
    $display("test reset values done");
    bus(1'b1, OFS_HI_EVT, 32'h0000_3002);
    bus(1'b1, OFS_POLARITY, 32'h0000_0403);
    bus(1'b1, OFS_HP_SET, 32'h0000_0401);
    bus(1'b1, OFS_EN_SET, 32'h0000_0001);
    bus(1'b1, OFS_TRIGGER, 32'h0000_0001);
    watch(20);
    check(32'(irq), 32'h0000_0008);
    rd(OFS_STATE, 32'h0000_0001);
    bus(1'b1, OFS_TRIGGER, 32'h0000_0000);
    watch(20);
    check(32'(irq), 32'h0000_0000);
    $display("test trigger interrupt done");
    bus(1'b1, OFS_TRIGGER, 32'h0001_0000);
    watch(8);
    rd(OFS_FLAGS, 32'h0000_0002);
    bus(1'b1, OFS_FLAGS, 32'h0000_0002);
    rd(OFS_FLAGS, 32'h0000_0000);
    $display("test disabled flag done");
    bus(1'b1, OFS_LO_EVT + 12'h008, 32'h0000_5002);
    bus(1'b1, OFS_EN_SET, 32'h0000_0004);
    tog(0);
    watch(20);
    check(32'(irq), 32'h0000_0000);
    tog(0);
    watch(20);
    check(32'(irq), 32'h0000_0020);
    $display("test falling pin done");
    bus(1'b1, 12'h1F0, 32'h1000_0000);
    bus(1'b1, 12'h1F4, 32'h2000_0000);
    bus(1'b1, 12'h1F8, 32'h0000_0001);
    bus(1'b1, 12'h1FC, 32'h0008_0004);
    bus(1'b1, OFS_HI_EVT + 12'h028, 32'h0000_0701);
    bus(1'b1, OFS_EN_SET, 32'h0000_0400);
    bus(1'b1, OFS_TRIGGER, 32'h0000_0002);
    watch(60);
    check(32'(hmv), 32'h0000_0001);
    check(32'(lmv), 32'h0000_0000);
    check(hs, 32'h1000_0004);
    check(hd, 32'h2000_0008);
    $display("test transfer done");
    bus(1'b1, 12'h280, 32'h1000_0000);
    bus(1'b1, 12'h284, 32'h3000_0000);
    bus(1'b1, 12'h288, 32'h0000_0001);
    bus(1'b1, 12'h28C, 32'h0000_0000);
    bus(1'b1, OFS_LO_EVT + 12'h02C, 32'h0000_0001);
    bus(1'b1, OFS_POLARITY, 32'h0000_0C03);
    bus(1'b1, OFS_EN_SET, 32'h0000_0800);
    bus(1'b1, OFS_TRIGGER, 32'h0000_0000);
    bus(1'b1, OFS_TRIGGER, 32'h0002_0002);
    watch(60);
    check(32'(hmv), 32'h0000_0001);
    check(32'(lmv), 32'h0000_0001);
    check(ls, 32'h1000_0000);
    check(ld, 32'h3000_0000);
    rd(OFS_STATUS, 32'h0000_0000);
    bus(1'b1, OFS_EN_CLR, 32'h0000_0001);
    rd(OFS_EN_SET, 32'h0000_0C04);
    bus(1'b1, OFS_HP_CLR, 32'h0000_0400);
    rd(OFS_HP_SET, 32'h0000_0001);
    $display("test two engines done");
    oreq <= 3'h3;
    oslv <= 9'h009;
    @(posedge clk);
    check(32'(og), 32'h0000_0001);
    $display("test crossbar done");
    conclude();
  end
endmodule
